/* hdl/tcm_mailbox.sv */
// Mailbox command interpreter with its shared byte memory and status flags.
// Assumes the host port and the front-end data are synchronous to clk_i.
// Behaviour
// RULE_01 - Host opens block read with 1010 low
// RULE_02 - Host waits pending flag high between steps
// RULE_03 - Pending flag high once command is fetched
// RULE_04 - Host sends 1011 with high channel
// RULE_05 - Block read fills each channel's slot first
// RULE_06 - Block read also refreshes cold-junction Celsius slot
// RULE_07 - Reply write drops reply flag, raises interrupt
// RULE_08 - Reply read raises flag, drops interrupt
// RULE_09 - Host polls reply flag or takes interrupt
// RULE_10 - Result byte is 100 plus code
// RULE_11 - Report 81 until parameters are loaded
// RULE_12 - Low above high channel reports 83
// RULE_13 - Result codes always carry top bit set
// RULE_14 - Byte c2 refreshes counts, then result
// RULE_15 - Host reads two count bytes per channel
// RULE_16 - Byte c0 answers with version nibbles
// RULE_17 - Byte c3 refreshes floats, then result
// RULE_18 - Voltage command stores sixteen inputs plus junction
// RULE_19 - Host reads four bytes only on success
// RULE_20 - Host mailbox write drops pending flag
// RULE_21 - Float region is four-byte slots per channel
// RULE_22 - Count region is two-byte slots per channel
// RULE_23 - Slot n at base plus 4n, LSB first
// RULE_24 - New commands wait until reply is read
`default_nettype none

module tcm_mailbox #(
  parameter logic [3:0] VERSION_UPPER = tcm_pkg::VERSION_UPPER_DEFAULT,
  parameter logic [3:0] VERSION_LOWER = tcm_pkg::VERSION_LOWER_DEFAULT
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire tcm_pkg::tcm_host_req_t host_req_i,
  output logic [7:0] host_rdata_o,
  input wire logic irq_enable_i,
  output logic cmd_pending_n_o,
  output logic reply_full_n_o,
  output logic irq_o,
  input wire tcm_pkg::tcm_chan_t [16:0] chan_i,
  input wire logic [31:0] cold_junction_ref_c_i,
  input wire logic [18:0][15:0] count_i
);
  import tcm_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DECODE,
    ST_FILL,
    ST_REPLY
  } tcm_state_t;

  logic [7:0] dpram_mem [0:1023];
  tcm_state_t state_reg;
  logic [7:0] cmd_reg;
  logic [7:0] fetched_reg;
  logic [7:0] reply_reg;
  logic [7:0] reply_next;
  logic cmd_pending_n_reg;
  logic reply_full_n_reg;
  logic sampling_loaded_reg;
  logic channel_loaded_reg;
  logic [3:0] first_channel_index_reg;
  logic [4:0] idx_reg;
  logic [4:0] last_reg;
  logic cjc_phase_reg;
  tcm_fill_t fill_reg;
  logic open_seen_reg;
  logic over_seen_reg;
  logic [7:0] rdata_reg;

  // ************************************************************
  // Host access decode.
  // ************************************************************
  wire host_cmd_wr = host_req_i.wr && (host_req_i.addr == CMD_MBOX_ADDR);
  wire host_reply_rd = host_req_i.rd && (host_req_i.addr == REPLY_MBOX_ADDR);
  wire host_mem_wr = host_req_i.wr && (host_req_i.addr != CMD_MBOX_ADDR) && (host_req_i.addr != REPLY_MBOX_ADDR);
  wire params_loaded = sampling_loaded_reg && channel_loaded_reg;
  wire [3:0] last_channel_index = fetched_reg[3:0];

  // ************************************************************
  // Fill step: slot address, data and width of the current write.
  // ************************************************************
  wire fill_active = (state_reg == ST_FILL);
  wire [9:0] float_addr = FLOAT_BASE + {3'h0, idx_reg, 2'h0}; // see RULE_23
  wire [9:0] count_addr = COUNT_BASE + {4'h0, idx_reg, 1'h0}; // see RULE_22
  wire [9:0] dev_addr = (fill_reg == FILL_COUNT) ? count_addr : float_addr;
  wire [31:0] temp_word = cjc_phase_reg ? cold_junction_ref_c_i : chan_i[idx_reg].temp; // see RULE_06
  wire [31:0] dev_data = (fill_reg == FILL_COUNT) ? {16'h0000, count_i[idx_reg]} :
                         (fill_reg == FILL_VOLT) ? chan_i[idx_reg].volt : temp_word;
  wire [2:0] dev_bytes = (fill_reg == FILL_COUNT) ? 3'(COUNT_SLOT_BYTES) : 3'(FLOAT_SLOT_BYTES); // see RULE_21
  wire fill_last = (idx_reg == last_reg) && (fill_reg != FILL_TEMP || cjc_phase_reg);
  wire count_tc = (fill_reg == FILL_TEMP) && !cjc_phase_reg;

  // Final result, worst fault first; top bits always 100.
  wire [4:0] fill_code = open_seen_reg ? RES_OPEN_TC : (over_seen_reg ? RES_OVER_RANGE : RES_OK);

  // ************************************************************
  // Shared memory: host writes, then device slot writes win.
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (host_mem_wr) begin
      dpram_mem[host_req_i.addr] <= host_req_i.wdata;
    end
    for (int b = 0; b < FLOAT_SLOT_BYTES; b++) begin
      if (fill_active && (3'(b) < dev_bytes)) begin
        dpram_mem[dev_addr + 10'(b)] <= dev_data[8*b +: 8]; // see RULE_05, RULE_23
      end
    end
  end

  // Registered read data, mailboxes held outside the array.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdata_reg <= 8'h00;
    end else if (host_req_i.rd) begin
      rdata_reg <= (host_req_i.addr == CMD_MBOX_ADDR) ? cmd_reg :
                   (host_req_i.addr == REPLY_MBOX_ADDR) ? reply_reg : dpram_mem[host_req_i.addr];
    end
  end

  // Command mailbox byte as written by the host.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cmd_reg <= 8'h00;
    end else if (host_cmd_wr) begin
      cmd_reg <= host_req_i.wdata;
    end
  end

  // ************************************************************
  // Status flags.
  // ************************************************************
  // Pending flag: a host write in the fetch cycle wins, so no command is lost.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cmd_pending_n_reg <= 1'b1;
    end else if (host_cmd_wr) begin
      cmd_pending_n_reg <= 1'b0; // see RULE_20
    end else if (state_reg == ST_IDLE && !cmd_pending_n_reg && reply_full_n_reg) begin
      cmd_pending_n_reg <= 1'b1; // see RULE_03
    end
  end

  // Reply flag: low when the reply is posted, high once the host reads it.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      reply_full_n_reg <= 1'b1;
    end else if (state_reg == ST_REPLY) begin
      reply_full_n_reg <= 1'b0; // see RULE_07
    end else if (host_reply_rd) begin
      reply_full_n_reg <= 1'b1; // see RULE_08
    end
  end

  // ************************************************************
  // Decode of a fetched command into its reply or a fill pass.
  // ************************************************************
  // Command classes of the fetched byte.
  wire is_block_lo = (fetched_reg[7:4] == CMD_BLOCK_LO_NIB);
  wire is_block_hi = (fetched_reg[7:4] == CMD_BLOCK_HI_NIB);
  wire is_single = (fetched_reg[7:4] == CMD_SINGLE_NIB);
  wire is_fill_cmd = (fetched_reg == CMD_COUNTS) || (fetched_reg == CMD_VOLTS) || is_block_hi || is_single;
  wire bad_order = is_block_hi && (first_channel_index_reg > last_channel_index); // see RULE_12
  wire start_fill = is_fill_cmd && params_loaded && !bad_order;

  // Immediate reply; a fill pass later replaces the success code with its own result.
  always_comb begin
    reply_next = {RESULT_PREFIX, RES_UNKNOWN}; // see RULE_13
    if (fetched_reg == CMD_VERSION) begin
      reply_next = {VERSION_UPPER, VERSION_LOWER}; // see RULE_16
    end else if (fetched_reg == CMD_CFG_SAMPLING || fetched_reg == CMD_CFG_CHANNEL || start_fill) begin
      reply_next = {RESULT_PREFIX, RES_OK};
    end else if (is_fill_cmd && !params_loaded) begin
      reply_next = {RESULT_PREFIX, RES_NOT_LOADED}; // see RULE_11
    end else if (bad_order) begin
      reply_next = {RESULT_PREFIX, RES_BAD_ORDER}; // see RULE_12
    end
  end

  // ************************************************************
  // Command sequencer.
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_reg <= ST_IDLE;
      fetched_reg <= 8'h00;
      reply_reg <= {RESULT_PREFIX, RES_NOT_LOADED}; // see RULE_11
      sampling_loaded_reg <= 1'b0;
      channel_loaded_reg <= 1'b0;
      first_channel_index_reg <= 4'h0;
      idx_reg <= 5'h00;
      last_reg <= 5'h00;
      cjc_phase_reg <= 1'b0;
      fill_reg <= FILL_TEMP;
      open_seen_reg <= 1'b0;
      over_seen_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (!cmd_pending_n_reg && reply_full_n_reg) begin // see RULE_24
            fetched_reg <= cmd_reg;
            state_reg <= ST_DECODE;
          end
        end
        ST_DECODE: begin
          open_seen_reg <= 1'b0;
          over_seen_reg <= 1'b0;
          cjc_phase_reg <= 1'b0;
          if (fetched_reg == CMD_CFG_SAMPLING) sampling_loaded_reg <= 1'b1;
          if (fetched_reg == CMD_CFG_CHANNEL) channel_loaded_reg <= 1'b1;
          // The low half of a block read posts nothing and leaves the reply byte alone.
          if (is_block_lo) begin
            first_channel_index_reg <= fetched_reg[3:0]; // see RULE_01
            state_reg <= ST_IDLE;
          end else if (start_fill) begin
            reply_reg <= reply_next;
            state_reg <= ST_FILL;
            if (fetched_reg == CMD_COUNTS) begin
              fill_reg <= FILL_COUNT; // see RULE_14
              idx_reg <= 5'h00;
              last_reg <= LAST_COUNT_SLOT;
            end else if (fetched_reg == CMD_VOLTS) begin
              fill_reg <= FILL_VOLT; // see RULE_17, RULE_18
              idx_reg <= 5'h00;
              last_reg <= CJC_SLOT;
            end else begin
              fill_reg <= FILL_TEMP; // see RULE_04
              idx_reg <= is_single ? {1'b0, last_channel_index} : {1'b0, first_channel_index_reg};
              last_reg <= {1'b0, last_channel_index};
            end
          end else begin
            reply_reg <= reply_next;
            state_reg <= ST_REPLY;
          end
        end
        ST_FILL: begin
          if (count_tc && chan_i[idx_reg].open_tc) open_seen_reg <= 1'b1;
          if (count_tc && chan_i[idx_reg].over_range) over_seen_reg <= 1'b1;
          if (fill_last) begin
            reply_reg <= {RESULT_PREFIX, fill_code}; // see RULE_10
            state_reg <= ST_REPLY;
          end else if (fill_reg == FILL_TEMP && idx_reg == last_reg) begin
            cjc_phase_reg <= 1'b1; // see RULE_06
            idx_reg <= CJC_SLOT;
            last_reg <= CJC_SLOT;
          end else begin
            idx_reg <= idx_reg + 5'h01;
          end
        end
        ST_REPLY: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // Outputs.
  // ************************************************************
  assign host_rdata_o = rdata_reg;
  assign cmd_pending_n_o = cmd_pending_n_reg;
  assign reply_full_n_o = reply_full_n_reg;
  assign irq_o = irq_enable_i && !reply_full_n_reg; // see RULE_07, RULE_08

endmodule : tcm_mailbox

`default_nettype wire

/* hdl/tcm_pkg.sv */
// Constants, commands, result codes and carrier types of the mailbox command interpreter.
// Assumes one 25 MHz clock shared by the host port, the front end and this block.
`default_nettype none

package tcm_pkg;

  // ************************************************************
  // Shared memory layout.
  // ************************************************************
  localparam int ADDR_W = 10;
  localparam logic [9:0] FLOAT_BASE = 10'h320;
  localparam logic [9:0] COUNT_BASE = 10'h370;
  localparam logic [9:0] CMD_MBOX_ADDR = 10'h3fe;
  localparam logic [9:0] REPLY_MBOX_ADDR = 10'h3ff;
  localparam int FLOAT_SLOT_BYTES = 4;
  localparam int COUNT_SLOT_BYTES = 2;
  localparam int NUM_TC = 16;
  localparam int NUM_FLOAT_SLOTS = 17;
  localparam int NUM_COUNT_SLOTS = 19;
  localparam logic [4:0] CJC_SLOT = 5'h10;
  localparam logic [4:0] LAST_COUNT_SLOT = 5'h12;

  // ************************************************************
  // Command bytes and nibbles.
  // ************************************************************
  localparam logic [7:0] CMD_CFG_SAMPLING = 8'h80;
  localparam logic [7:0] CMD_CFG_CHANNEL = 8'h81;
  localparam logic [3:0] CMD_SINGLE_NIB = 4'h9;
  localparam logic [3:0] CMD_BLOCK_LO_NIB = 4'ha;
  localparam logic [3:0] CMD_BLOCK_HI_NIB = 4'hb;
  localparam logic [7:0] CMD_VERSION = 8'hc0;
  localparam logic [7:0] CMD_COUNTS = 8'hc2;
  localparam logic [7:0] CMD_VOLTS = 8'hc3;

  // ************************************************************
  // Result codes: top three bits 100, low five the code field.
  // ************************************************************
  localparam logic [2:0] RESULT_PREFIX = 3'h4;
  localparam logic [4:0] RES_OK = 5'h00;
  localparam logic [4:0] RES_NOT_LOADED = 5'h01;
  localparam logic [4:0] RES_OVER_RANGE = 5'h02;
  localparam logic [4:0] RES_BAD_ORDER = 5'h03;
  localparam logic [4:0] RES_UNKNOWN = 5'h04;
  localparam logic [4:0] RES_OPEN_TC = 5'h05;

  // Version reply nibbles; values are arbitrary.
  localparam logic [3:0] VERSION_UPPER_DEFAULT = 4'h1;
  localparam logic [3:0] VERSION_LOWER_DEFAULT = 4'h0;

  // One float channel as produced by the front end.
  typedef struct packed {
    logic [31:0] temp;
    logic [31:0] volt;
    logic open_tc;
    logic over_range;
  } tcm_chan_t;

  // Host access to the shared memory.
  typedef struct packed {
    logic [9:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } tcm_host_req_t;

  typedef enum logic [1:0] {
    FILL_TEMP,
    FILL_VOLT,
    FILL_COUNT
  } tcm_fill_t;

endpackage : tcm_pkg

`default_nettype wire

/* sim/tcm_mailbox_chk.sv */
// Checker for the mailbox flags, interrupt and read data of the interpreter.
// Assumes one clock and a synchronous active-high reset; attached by bind.
`default_nettype none

module tcm_mailbox_chk (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire tcm_pkg::tcm_host_req_t host_req_i,
  input wire logic [7:0] host_rdata_o,
  input wire logic irq_enable_i,
  input wire logic cmd_pending_n_o,
  input wire logic reply_full_n_o,
  input wire logic irq_o
);
  import tcm_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // ************************************************************
  // Host access decode.
  // ************************************************************
  wire logic cmd_wr = host_req_i.wr && (host_req_i.addr == CMD_MBOX_ADDR);
  wire logic reply_rd = host_req_i.rd && (host_req_i.addr == REPLY_MBOX_ADDR);
  property p_wr_pend; cmd_wr |=> !cmd_pending_n_o; endproperty
  property p_wr_other; host_req_i.wr && !cmd_wr && cmd_pending_n_o |=> cmd_pending_n_o; endproperty
  property p_pend_fetch; $fell(cmd_pending_n_o) |-> ##[1:60] (cmd_pending_n_o || !reply_full_n_o); endproperty
  property p_pend_hold; !cmd_pending_n_o && !reply_full_n_o && !host_req_i.rd |=> !cmd_pending_n_o; endproperty
  property p_full_hold; !reply_full_n_o && !reply_rd |=> !reply_full_n_o; endproperty
  property p_rd_clear; reply_rd |=> reply_full_n_o && !irq_o; endproperty
  property p_irq; irq_o == (irq_enable_i && !reply_full_n_o); endproperty
  property p_rdata_hold; (!host_req_i.rd)[*2] |=> $stable(host_rdata_o); endproperty
  a_wr_pend: assert property (p_wr_pend) else $error("pending flag not low after command write");
  a_wr_other: assert property (p_wr_other) else $error("pending flag moved on other write");
  a_pend_fetch: assert property (p_pend_fetch) else $error("command never fetched");
  a_pend_hold: assert property (p_pend_hold) else $error("command fetched before reply read");
  a_full_hold: assert property (p_full_hold) else $error("reply flag rose without read");
  a_rd_clear: assert property (p_rd_clear) else $error("reply read did not clear flag");
  a_irq: assert property (p_irq) else $error("interrupt not tied to reply flag");
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without read");
  c_irq: cover property (irq_o);
  c_wait: cover property (!cmd_pending_n_o && !reply_full_n_o);
  c_fetch: cover property ($rose(cmd_pending_n_o));
endmodule // tcm_mailbox_chk

bind tcm_mailbox tcm_mailbox_chk i_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .host_req_i(host_req_i),
  .host_rdata_o(host_rdata_o), .irq_enable_i(irq_enable_i), .cmd_pending_n_o(cmd_pending_n_o),
  .reply_full_n_o(reply_full_n_o), .irq_o(irq_o));
`default_nettype wire

/* sim/tcm_host_model.sv */
// Host software model: byte accesses to shared memory and mailbox commands.
// Assumes one-cycle request pulses and read data one cycle after the read.
`default_nettype none

module tcm_host_model (
  input wire logic clk_i,
  output var tcm_pkg::tcm_host_req_t host_req_o,
  input wire logic [7:0] host_rdata_i,
  input wire logic cmd_pending_n_i,
  input wire logic reply_full_n_i
);
  timeunit 1ns;
  timeprecision 1ps;
  import tcm_pkg::*;
  int n_late = 0;
  initial host_req_o = '0;
  // One-cycle access; idle address and data lines then show the inverse of the last request, strobes low.
  task automatic acc(input logic [9:0] a, input logic w, input logic r, input logic [7:0] d);
    @(posedge clk_i);
    host_req_o <= '{addr: a, wr: w, rd: r, wdata: d};
    @(posedge clk_i);
    host_req_o <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
  endtask
  task automatic rd(input logic [9:0] a, output logic [7:0] q);
    acc(a, 1'b0, 1'b1, 8'h00);
    @(posedge clk_i);
    #1 q = host_rdata_i;
  endtask
  // Bounded poll: fetch seen (pend) or reply posted (not pend).
  task automatic hold_until(input bit pend);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      #1 n++;
    end while ((pend ? cmd_pending_n_i !== 1'b1 : reply_full_n_i !== 1'b0) && n < 200);
    // A poll that runs out is counted, so the bench can fail the run.
    if (pend ? cmd_pending_n_i !== 1'b1 : reply_full_n_i !== 1'b0) begin
      n_late++;
    end
  endtask
  task automatic cmd(input logic [7:0] c, output logic [7:0] q);
    acc(CMD_MBOX_ADDR, 1'b1, 1'b0, c);
    hold_until(1'b0);
    rd(REPLY_MBOX_ADDR, q);
  endtask
  task automatic block(input logic [3:0] lo, input logic [3:0] hi, output logic [7:0] q);
    acc(CMD_MBOX_ADDR, 1'b1, 1'b0, {CMD_BLOCK_LO_NIB, lo});
    hold_until(1'b1);
    cmd({CMD_BLOCK_HI_NIB, hi}, q);
  endtask
endmodule // tcm_host_model
`default_nettype wire

/* sim/tcm_mailbox_tb_top.sv */
// Self-checking bench for the mailbox command interpreter.
// Assumes the host model and the bound checker are compiled beside it.
`default_nettype none

module tcm_mailbox_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tcm_pkg::*;
  localparam logic [3:0] VER_HI = 4'h5; // Arbitrary version nibbles.
  localparam logic [3:0] VER_LO = 4'h3;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic irq_enable_i = 1'b0;
  tcm_host_req_t host_req;
  logic [7:0] rdata;
  logic pend_n;
  logic full_n;
  logic irq;
  tcm_chan_t [16:0] chan;
  logic [31:0] cj = 32'h3f8c0000;
  logic [18:0][15:0] cnt;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  logic [7:0] q;
  logic [31:0] w;

  tcm_mailbox #(.VERSION_UPPER(VER_HI), .VERSION_LOWER(VER_LO)) i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .host_req_i(host_req), .host_rdata_o(rdata), .irq_enable_i(irq_enable_i), .cmd_pending_n_o(pend_n),
    .reply_full_n_o(full_n), .irq_o(irq), .chan_i(chan), .cold_junction_ref_c_i(cj), .count_i(cnt));
  tcm_host_model i_host (.clk_i(clk_i), .host_req_o(host_req), .host_rdata_i(rdata),
    .cmd_pending_n_i(pend_n), .reply_full_n_i(full_n));

  // Clock and cycle ceiling.
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      close_out();
    end
  end
  function automatic logic [31:0] temp_of(int n);
    return 32'h11223300 + n;
  endfunction
  function automatic logic [31:0] volt_of(int n);
    return 32'h55667700 + n;
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Reads nb bytes, least significant first.
  task automatic rd_val(input logic [9:0] a, input int nb, output logic [31:0] v);
    logic [7:0] b;
    v = '0;
    for (int i = 0; i < nb; i++) begin
      i_host.rd(10'(a + i), b);
      v[8*i+:8] = b;
    end
  endtask
  task automatic close_out();
    if (n_mismatch == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ************************************************************
  // Scenarios.
  // ************************************************************
  task automatic t_reset();
    check("flags", {pend_n, full_n, irq}, 3'b110);
    i_host.rd(REPLY_MBOX_ADDR, q);
    check("power-up result", q, 8'h81);
    i_host.cmd(CMD_VOLTS, q);
    check("unloaded result", q, 8'h81);
    i_host.cmd(CMD_CFG_SAMPLING, q);
    i_host.cmd(CMD_CFG_CHANNEL, q);
    check("config result", q, 8'h80);
  endtask
  task automatic t_version();
    @(posedge clk_i);
    irq_enable_i <= 1'b1;
    i_host.acc(CMD_MBOX_ADDR, 1'b1, 1'b0, CMD_VERSION);
    i_host.hold_until(1'b0);
    check("irq raised", {full_n, irq}, 2'b01);
    i_host.rd(REPLY_MBOX_ADDR, q);
    check("version", q, {VER_HI, VER_LO});
    check("irq dropped", {full_n, irq}, 2'b10);
  endtask
  task automatic t_block();
    i_host.acc(10'h338, 1'b1, 1'b0, 8'h5a);
    i_host.block(4'h3, 4'h5, q);
    check("block result", q, 8'h80);
    for (int n = 3; n <= 5; n++) begin
      rd_val(10'(FLOAT_BASE + 4 * n), 4, w);
      check("block temp", w, temp_of(n));
    end
    rd_val(10'h360, 4, w);
    check("cold junction", w, cj);
    rd_val(10'h338, 1, w);
    check("slot outside block", w, 32'h5a);
    i_host.cmd({CMD_SINGLE_NIB, 4'h9}, q);
    check("single result", q, 8'h80);
    rd_val(10'(FLOAT_BASE + 36), 4, w);
    check("single temp", w, temp_of(9));
  endtask
  task automatic t_errors();
    i_host.block(4'h5, 4'h2, q);
    check("order result", q, 8'h83);
    @(posedge clk_i);
    chan[7].open_tc <= 1'b1;
    chan[7].over_range <= 1'b1;
    chan[8].over_range <= 1'b1;
    i_host.block(4'h7, 4'h7, q);
    check("open result", q, 8'h85);
    i_host.block(4'h8, 4'h8, q);
    check("range result", q, 8'h82);
    i_host.cmd(8'hc7, q);
    check("unknown result", q, 8'h84);
  endtask
  task automatic t_fill();
    i_host.cmd(CMD_COUNTS, q);
    check("count result", q, 8'h80);
    rd_val(COUNT_BASE, 2, w);
    check("first count", w, 32'hc000);
    rd_val(10'(COUNT_BASE + 36), 2, w);
    check("last count", w, 32'hc012);
    i_host.cmd(CMD_VOLTS, q);
    check("volt result", q, 8'h80);
    rd_val(FLOAT_BASE, 4, w);
    check("volt 0", w, volt_of(0));
    rd_val(10'h360, 4, w);
    check("volt junction", w, volt_of(16));
  endtask
  task automatic t_wait();
    i_host.acc(CMD_MBOX_ADDR, 1'b1, 1'b0, CMD_VERSION);
    i_host.hold_until(1'b0);
    i_host.acc(CMD_MBOX_ADDR, 1'b1, 1'b0, CMD_COUNTS);
    repeat (40) @(posedge clk_i);
    #1 check("held command", {pend_n, full_n}, 2'b00);
    i_host.rd(REPLY_MBOX_ADDR, q);
    check("first reply", q, {VER_HI, VER_LO});
    i_host.hold_until(1'b0);
    i_host.rd(REPLY_MBOX_ADDR, q);
    check("queued reply", q, 8'h80);
  endtask
  // Main sequence.
  initial begin
    for (int i = 0; i < 17; i++) begin
      chan[i] = '{temp: temp_of(i), volt: volt_of(i), open_tc: 1'b0, over_range: 1'b0};
    end
    for (int i = 0; i < 19; i++) begin
      cnt[i] = 16'hc000 + 16'(i);
    end
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    #1 t_reset();
    t_version();
    t_block();
    t_errors();
    t_fill();
    t_wait();
    check("poll timeouts", i_host.n_late, 32'h0);
    close_out();
  end
endmodule // tcm_mailbox_tb_top
`default_nettype wire
